//--- hdl/pmc_button.sv
/*
 Debounced button with a one-cycle press pulse.
 Assumes a level input synchronous to ref_clk_in, active high.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pmc_cfg.svh"
module pmc_button #(
    parameter int CNT = `PMC_DEBOUNCE_CYC
) (
    // Clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    // Button
    input  wire logic raw_in,
    output logic      press_out
);
    if (CNT < 1)
        $error("CNT must be at least 1");
    localparam int CW = $clog2(CNT + 1);
    logic [CW-1:0] cnt;
    logic          sync0;
    logic          sync1;
    logic          level;
    // Two flop synchroniser
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            sync0 <= 1'b0;
            sync1 <= 1'b0;
        end
        else
        begin
            sync0 <= raw_in;
            sync1 <= sync0;
        end
    end
    // Stable level accepted after CNT cycles, pulse on rise
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            cnt       <= '0;
            level     <= 1'b0;
            press_out <= 1'b0;
        end
        else
        begin
            press_out <= 1'b0;
            if (sync1 == level)
                cnt <= '0;
            else if (cnt == CW'(CNT - 1))
            begin
                cnt       <= '0;
                level     <= sync1;
                press_out <= sync1;
            end
            else
                cnt <= cnt + 1'b1;
        end
    end
    press_once_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        press_out |=> !press_out)
        else $error("press pulse longer than one cycle");
endmodule
`default_nettype wire

//--- hdl/pmc_cfg.svh
/*
 Constants for the printer mechanism control block.
 Assumes a 25 MHz ref_clk_in and inputs synchronous to it.
*/
// How it works
// - Both stepper windings energised while moving
// - Leading phase by quarter cycle sets direction
// - Column position from three transducer pulse trains
// - Home relay change starts precise optical homing
// - Nine vertical head pins fired per column
// - Paper feed single lines, forward only
// - Feed motor stopped by reed relay pulses
// - Paper end near inhibits printing following lines
// - Selector picks pin feed or roll paper
// - Online lamp lit; press goes off line
// - Form feed off line: top of form, carriage left
// - Form feed also clears paper out inhibit
// - Form set off line: set top, self test
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
`define PMC_CLK_MHZ        25
`define PMC_DEBOUNCE_US    5000
`define PMC_DEBOUNCE_CYC   (`PMC_DEBOUNCE_US * `PMC_CLK_MHZ)
`define PMC_STEP_US        400
`define PMC_STEP_CYC       (`PMC_STEP_US * `PMC_CLK_MHZ)
`define PMC_FIRE_US        300
`define PMC_FIRE_CYC       (`PMC_FIRE_US * `PMC_CLK_MHZ)
`define PMC_COL_W          8
`define PMC_LINE_W         8
`define PMC_FORM_LINES     66
`define PMC_HOME_COL       8'h00
`define PMC_PHASE_FWD      2'h1
`define PMC_PHASE_REV      2'h3
`endif

//--- hdl/pmc_pkg.sv
/*
 Types shared by the printer mechanism control block.
 Assumes nothing of its surroundings.
*/
package pmc_pkg;
    typedef enum logic [2:0] {
        PMC_IDLE, PMC_HOMING, PMC_MOVE, PMC_FEED, PMC_TEST
    } pmc_state_t;
endpackage

//--- hdl/pmc_top.sv
/*
 Printer mechanism control: carriage stepper, position, homing, head,
 line feed, paper out and operator panel.
 Assumes all inputs synchronous to ref_clk_in; panel presses arrive as
 levels on the panel connectors.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pmc_cfg.svh"
module pmc_top #(
    parameter int DEBOUNCE_CYC = `PMC_DEBOUNCE_CYC,
    parameter int STEP_CYC     = `PMC_STEP_CYC,
    parameter int FIRE_CYC     = `PMC_FIRE_CYC
) (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // Host commands
    input  wire logic        move_req_in,
    input  wire logic        move_dir_in,
    input  wire logic [7:0]  target_col_in,
    input  wire logic        print_req_in,
    input  wire logic [8:0]  print_dots_in,
    input  wire logic        line_feed_req_in,
    input  wire logic        host_online_req_in,
    // Mechanism sense
    input  wire logic        transducer_pulse_a_in,
    input  wire logic        transducer_pulse_b_in,
    input  wire logic        transducer_pulse_c_in,
    input  wire logic        home_relay_in,
    input  wire logic        feed_reed_in,
    input  wire logic        paper_low_in,
    input  wire logic        pin_feed_sel_in,
    input  wire logic        paginate_mark_in,
    // Panel connectors
    input  wire logic        panel_online_request_connector_in,
    input  wire logic        panel_form_set_in,
    input  wire logic        panel_form_feed_in,
    // Drive outputs
    output logic [1:0]       phase_out,
    output logic [8:0]       head_pins_out,
    output logic             feed_motor_out,
    output logic             online_led_out,
    // Status
    output logic             online_out,
    output logic             inhibit_out,
    output logic             homed_out,
    output logic             busy_out,
    output logic             self_test_out,
    output logic [7:0]       column_out,
    output logic [7:0]       line_out,
    output logic [7:0]       top_line_out
);
    if (STEP_CYC < 2 || FIRE_CYC < 1)
        $error("step or fire count too small");
    localparam int SW = $clog2(STEP_CYC + 1);
    localparam int FW = $clog2(FIRE_CYC + 1);
    pmc_pkg::pmc_state_t state;
    logic [SW-1:0] step_cnt;
    logic [FW-1:0] fire_cnt;
    logic [1:0]    quad;
    logic          dir;
    logic          reed_q;
    logic          home_q;
    logic          a_q;
    logic [7:0]    next_line;
    logic          ff_pending;
    logic          p_online;
    logic          p_set;
    logic          p_feed;
    logic          next_homing;
    logic          step_tick;
    logic          reed_edge;
    logic          paper_end;
    // Panel buttons
    pmc_button #(.CNT(DEBOUNCE_CYC)) u_online (.ref_clk_in(ref_clk_in),
        .rst_in(rst_in), .raw_in(panel_online_request_connector_in),
        .press_out(p_online));
    pmc_button #(.CNT(DEBOUNCE_CYC)) u_set (.ref_clk_in(ref_clk_in),
        .rst_in(rst_in), .raw_in(panel_form_set_in), .press_out(p_set));
    pmc_button #(.CNT(DEBOUNCE_CYC)) u_feed (.ref_clk_in(ref_clk_in),
        .rst_in(rst_in), .raw_in(panel_form_feed_in), .press_out(p_feed));
    // Event decodes
    assign step_tick   = (step_cnt == SW'(STEP_CYC - 1));
    assign reed_edge   = feed_reed_in ^ reed_q;
    // Selector chooses which detector output means paper end
    assign paper_end   = pin_feed_sel_in ? paginate_mark_in
                                         : paper_low_in;
    assign next_homing = home_relay_in ^ home_q;
    assign busy_out    = (state != pmc_pkg::PMC_IDLE);
    assign online_led_out = online_out;
    // Next line number, wrapping at the form length
    assign next_line   = (line_out == 8'(`PMC_FORM_LINES - 1)) ? 8'h00
                                                               : line_out + 1'b1;
    // Input edge history
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            {reed_q, home_q, a_q} <= 3'h0;
        else
            {reed_q, home_q, a_q} <= {feed_reed_in, home_relay_in,
                                      transducer_pulse_a_in};
    end
    // Step timer
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in || step_tick)
            step_cnt <= '0;
        else
            step_cnt <= step_cnt + 1'b1;
    end
    // Quadrature phase pattern; index realigned to the windings when idle
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            quad      <= 2'h0;
            phase_out <= 2'h0;
        end
        else if (state == pmc_pkg::PMC_MOVE || state == pmc_pkg::PMC_HOMING)
        begin
            if (step_tick)
                quad <= quad + (dir ? `PMC_PHASE_REV : `PMC_PHASE_FWD);
            phase_out <= {quad[1], quad[1] ^ quad[0]};
        end
        else
            quad <= {phase_out[1], phase_out[1] ^ phase_out[0]};
    end
    // Column counting from transducer pulses
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            column_out <= `PMC_HOME_COL;
        else if (state == pmc_pkg::PMC_HOMING && transducer_pulse_c_in)
            column_out <= `PMC_HOME_COL;
        else if (transducer_pulse_a_in && !a_q)
        begin
            // Pulse b level gives sense of travel
            if (transducer_pulse_b_in)
                column_out <= column_out - 1'b1;
            else
                column_out <= column_out + 1'b1;
        end
    end
    // Main sequencer
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            state         <= pmc_pkg::PMC_HOMING;
            dir           <= 1'b1;
            homed_out     <= 1'b0;
            feed_motor_out <= 1'b0;
            ff_pending    <= 1'b0;
            self_test_out <= 1'b0;
        end
        else
        begin
            case (state)
                pmc_pkg::PMC_IDLE:
                begin
                    self_test_out <= 1'b0;
                    if (!online_out && p_feed)
                    begin
                        ff_pending <= 1'b1;
                        state      <= pmc_pkg::PMC_FEED;
                    end
                    else if (!online_out && p_set)
                        state <= pmc_pkg::PMC_TEST;
                    else if (line_feed_req_in)
                        state <= pmc_pkg::PMC_FEED;
                    else if (move_req_in && target_col_in != column_out)
                    begin
                        dir   <= move_dir_in;
                        state <= pmc_pkg::PMC_MOVE;
                    end
                end
                pmc_pkg::PMC_MOVE:
                    if (column_out == target_col_in)
                        state <= pmc_pkg::PMC_IDLE;
                pmc_pkg::PMC_HOMING:
                    if (transducer_pulse_c_in && home_q != home_relay_in)
                    begin
                        homed_out <= 1'b1;
                        state     <= pmc_pkg::PMC_IDLE;
                    end
                    else if (transducer_pulse_c_in && homed_out)
                        state <= pmc_pkg::PMC_IDLE;
                    else if (next_homing)
                        homed_out <= 1'b1;
                pmc_pkg::PMC_FEED:
                begin
                    feed_motor_out <= 1'b1;
                    if (reed_edge && feed_motor_out)
                    begin
                        feed_motor_out <= 1'b0;
                        if (ff_pending && next_line != top_line_out)
                            state <= pmc_pkg::PMC_FEED;
                        else
                        begin
                            ff_pending <= 1'b0;
                            dir        <= 1'b1;
                            state      <= ff_pending ? pmc_pkg::PMC_HOMING
                                                     : pmc_pkg::PMC_IDLE;
                        end
                    end
                end
                pmc_pkg::PMC_TEST:
                begin
                    self_test_out <= 1'b1;
                    state         <= pmc_pkg::PMC_IDLE;
                end
                default:
                    state <= pmc_pkg::PMC_IDLE;
            endcase
        end
    end
    // Line and top of form tracking
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            {line_out, top_line_out} <= 16'h0000;
        else
        begin
            if (state == pmc_pkg::PMC_FEED && reed_edge && feed_motor_out)
                line_out <= next_line;
            if (state == pmc_pkg::PMC_IDLE && !online_out && p_set)
                top_line_out <= line_out;
        end
    end
    // On line control, paper out inhibit
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            {online_out, inhibit_out} <= 2'h0;
        else
        begin
            if (p_online && online_out)
                online_out <= 1'b0;
            else if (host_online_req_in)
                online_out <= 1'b1;
            // Set wins over the clear by a form feed press
            if (paper_end && line_feed_req_in)
                inhibit_out <= 1'b1;
            else if (p_feed && !online_out && !paper_end)
                inhibit_out <= 1'b0;
        end
    end
    // Head pin firing, one column of nine dots
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            {fire_cnt, head_pins_out} <= '0;
        else if (fire_cnt != '0)
        begin
            fire_cnt <= fire_cnt - 1'b1;
            if (fire_cnt == FW'(1))
                head_pins_out <= 9'h000;
        end
        else if (print_req_in && !inhibit_out && state == pmc_pkg::PMC_MOVE)
        begin
            fire_cnt      <= FW'(FIRE_CYC);
            head_pins_out <= print_dots_in;
        end
    end
    // Checks
    sequence feed_done_s;
        reed_edge && feed_motor_out && state == pmc_pkg::PMC_FEED;
    endsequence
    feed_stop_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        feed_done_s |=> !feed_motor_out)
        else $error("feed motor did not stop on reed pulse");
    inhibit_fire_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        inhibit_out && fire_cnt == '0 |=> head_pins_out == 9'h000)
        else $error("head fired while inhibited");
    online_rise_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        $rose(online_out) |-> $past(host_online_req_in))
        else $error("went on line without a request");
    offline_press_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        p_online && online_out |=> !online_out)
        else $error("online press did not go off line");
    feed_ignored_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        p_feed && online_out && state == pmc_pkg::PMC_IDLE
        && !line_feed_req_in |=> state != pmc_pkg::PMC_FEED)
        else $error("form feed acted on line");
    set_top_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state == pmc_pkg::PMC_IDLE && !online_out && p_set
        |=> top_line_out == $past(line_out))
        else $error("form set did not record line");
    restart_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        p_feed && !online_out && !paper_end && !line_feed_req_in
        |=> !inhibit_out)
        else $error("form feed did not clear inhibit");
    both_phase_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state == pmc_pkg::PMC_MOVE && step_tick && column_out != target_col_in
        |=> ##1 phase_out != $past(phase_out, 2))
        else $error("stepper phases did not advance");
endmodule
`default_nettype wire

//--- testbench/pmc_mech_model.sv
/*
 Mechanism model: carriage stepper with optical transducer, home relay
 and a line feed motor whose reed relay flips once per line.
 Assumes the controller drives phases and motor on ref_clk_in.
*/
`timescale 1ns/100ps
`default_nettype none
module pmc_mech_model (
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rst_in,
    // Drive from the controller
    input  wire logic [1:0] phase_in,
    input  wire logic       feed_motor_in,
    input  wire logic       slow_in,
    // Sense lines back
    output logic            pulse_a_out,
    output logic            pulse_b_out,
    output logic            pulse_c_out,
    output logic            home_relay_out,
    output logic            feed_reed_out,
    output var int          pos_out
);
    logic [1:0] last_phase;
    logic       rev;
    int         feed_cnt;

    // Reverse when the other winding leads
    assign rev = (phase_in != {last_phase[0], ~last_phase[1]});
    // Index mark and coarse relay near home
    assign pulse_c_out    = (pos_out == 0);
    assign home_relay_out = (pos_out < 3);

    // Each winding change moves one column and gives one pulse
    always_ff @(posedge ref_clk_in)
    begin
        last_phase  <= phase_in;
        pulse_a_out <= 1'b0;
        if (rst_in)
        begin
            pos_out     <= 0;
            pulse_b_out <= 1'b0;
        end
        else if (phase_in != last_phase)
        begin
            pulse_a_out <= 1'b1;
            pulse_b_out <= rev;
            pos_out     <= rev ? pos_out - 1 : pos_out + 1;
        end
    end

    // Reed flips after the roller turns a line, quickly or slowly
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in || !feed_motor_in)
            feed_cnt <= 0;
        else
            feed_cnt <= feed_cnt + 1;
        if (rst_in)
            feed_reed_out <= 1'b0;
        else if (feed_motor_in && feed_cnt == (slow_in ? 12 : 3))
            feed_reed_out <= ~feed_reed_out;
    end
endmodule
`default_nettype wire

//--- testbench/test_printer_mechanism_control.sv
/*
 Self-checking bench for the printer mechanism control block.
 Assumes pmc_top and the mechanism model; short debounce and step counts.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
    $display("BAD %0t line %0d", $time, `__LINE__); end end
module test_printer_mechanism_control;
    logic       ref_clk_in, rst_in, move_req, move_dir, print_req, lf_req;
    logic       host_on, paper_low, pin_sel, mark, slow, pa, pb, pc, home;
    logic       reed, motor, led, online, inhibit, homed, busy, stest;
    logic [7:0] target, col, line, top;
    logic [8:0] dots, pins, seen;
    logic [2:0] btn;
    logic [1:0] phase;
    int         pos, f, pin_hits, tests, feeds, miscompares, compares;
    logic       motor_d;

    pmc_top #(.DEBOUNCE_CYC(4), .STEP_CYC(4), .FIRE_CYC(2)) uut (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .move_req_in(move_req),
        .move_dir_in(move_dir), .target_col_in(target),
        .print_req_in(print_req), .print_dots_in(dots),
        .line_feed_req_in(lf_req), .host_online_req_in(host_on),
        .transducer_pulse_a_in(pa), .transducer_pulse_b_in(pb),
        .transducer_pulse_c_in(pc), .home_relay_in(home),
        .feed_reed_in(reed), .paper_low_in(paper_low),
        .pin_feed_sel_in(pin_sel), .paginate_mark_in(mark),
        .panel_online_request_connector_in(btn[0]),
        .panel_form_set_in(btn[1]), .panel_form_feed_in(btn[2]),
        .phase_out(phase), .head_pins_out(pins), .feed_motor_out(motor),
        .online_led_out(led), .online_out(online), .inhibit_out(inhibit),
        .homed_out(homed), .busy_out(busy), .self_test_out(stest),
        .column_out(col), .line_out(line), .top_line_out(top));

    pmc_mech_model mech (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .phase_in(phase),
        .feed_motor_in(motor), .slow_in(slow), .pulse_a_out(pa),
        .pulse_b_out(pb), .pulse_c_out(pc), .home_relay_out(home),
        .feed_reed_out(reed), .pos_out(pos));

    // Clock
    initial
    begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end

    // Watch head pins, self test pulses and motor starts
    always @(posedge ref_clk_in)
    begin
        motor_d <= motor;
        if (pins !== 9'h000)
        begin
            seen <= pins;
            pin_hits++;
        end
        if (stest === 1'b1)
            tests++;
        if (motor === 1'b1 && motor_d === 1'b0)
            feeds++;
    end

    task cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    task wait_idle;
        int i;
        i = 0;
        cyc(2);
        while (busy !== 1'b0 && i < 5000)
        begin
            cyc(1);
            i++;
        end
        `CHK(busy, 1'b0)
    endtask

    task lf;
        lf_req <= 1'b1;
        cyc(1);
        lf_req <= 1'b0;
        wait_idle;
    endtask

    task move(input logic [7:0] t, input logic d, input logic p);
        target    <= t;
        move_dir  <= d;
        print_req <= p;
        move_req  <= 1'b1;
        cyc(1);
        move_req  <= 1'b0;
        wait_idle;
        print_req <= 1'b0;
    endtask

    // Hold a panel button well past debounce, then release
    task press(input int k);
        btn[k] <= 1'b1;
        cyc(20);
        btn[k] <= 1'b0;
        cyc(20);
        wait_idle;
    endtask

    task results;
        if (miscompares == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        cyc(30000);
        miscompares++;
        results;
    end

    // Tests
    initial
    begin
        {rst_in, move_req, move_dir, print_req, lf_req} = 5'h10;
        {host_on, paper_low, pin_sel, mark, slow} = 5'h00;
        target = 8'h00;
        dots   = 9'h000;
        btn    = 3'h0;
        cyc(8);
        `CHK(online, 1'b0)
        `CHK(inhibit, 1'b0)
        `CHK(motor, 1'b0)
        `CHK(pins, 9'h000)
        rst_in <= 1'b0;
        wait_idle;
        `CHK(homed, 1'b1)
        lf();
        `CHK(line, 8'h01)
        `CHK(motor, 1'b0)
        `CHK(feeds, 1)
        slow <= 1'b1;
        lf();
        `CHK(line, 8'h02)
        slow <= 1'b0;
        dots <= 9'h1A5;
        move(8'h05, 1'b0, 1'b1);
        `CHK(col, 8'h05)
        `CHK(pos, 5)
        `CHK(seen, 9'h1A5)
        move(8'h02, 1'b1, 1'b0);
        `CHK(col, 8'h02)
        `CHK(pos, 2)
        press(1);
        `CHK(top, 8'h02)
        `CHK(tests, 1)
        host_on <= 1'b1;
        cyc(1);
        host_on <= 1'b0;
        cyc(4);
        `CHK(online, 1'b1)
        `CHK(led, 1'b1)
        press(2);
        `CHK(line, 8'h02)
        press(0);
        `CHK(online, 1'b0)
        `CHK(led, 1'b0)
        paper_low <= 1'b1;
        lf();
        `CHK(inhibit, 1'b1)
        pin_hits = 0;
        move(8'h06, 1'b0, 1'b1);
        `CHK(pin_hits, 0)
        paper_low <= 1'b0;
        f = feeds;
        press(2);
        `CHK(inhibit, 1'b0)
        `CHK(col, 8'h00)
        `CHK(feeds > f, 1'b1)
        `CHK(line, 8'h02)
        pin_sel <= 1'b1;
        mark    <= 1'b1;
        lf();
        `CHK(inhibit, 1'b1)
        pin_sel <= 1'b0;
        press(2);
        lf();
        `CHK(inhibit, 1'b0)
        results;
    end
endmodule
`default_nettype wire
